// File: clock_select_reset_control.sv
// Clock selection, auxiliary clock gating and reset control, AXI4-Lite.
//
// Overview of operation
// RULE1: Derive audio and transcoder clocks from main clock.
// RULE2: Power-up counter loads ones, counts after stability.
// RULE3: Release reset at zero count and pin high.
// RULE4: External source holds reset pin until clock stops.
// RULE5: Slow select: 0 prescaled main, 1 oscillator.
// RULE6: Fast select: 0 PLL, 1 main; resets 1.
// RULE7: Ignore clearing fast select while PLL down.
// RULE8: Fast select clears only after PLL stable.
// RULE9: Power-down bit stops PLL; resets to 1.
// RULE10: Ignore setting power-down while fast select clear.
// RULE11: Aux clock one runs when enabled, main good.
// RULE12: Aux clock two runs when enabled, main good.
// RULE13: Power-on flag set by power-up, cleared only.
// RULE14: Control register bit positions as specified.
// RULE15: Main oscillator stop presets timer; zero means good.
// RULE16: Aux clock divides main clock by field plus one.
// RULE17: Source switching and gating are glitch free.
`timescale 1ns/10ps
`include "clock_reset_cfg.svh"

module clock_select_reset_control
   import clock_reset_pkg::*;
#(
   parameter int ADDR_W = 32,
   parameter int TIMER_W = `STARTUP_TIMER_WIDTH,
   parameter logic [TIMER_W-1:0] TIMER_PRESET = `STARTUP_TIMER_PRESET
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic stop_main_osc,
   input wire logic main_osc_running,
   input wire logic reset_pin_n,
   input wire logic pll_stable,
   input wire logic slow_osc_in,
   output logic internal_reset_n,
   output logic main_clock_good,
   output logic pll_stop,
   output logic fast_source_select,
   output logic [7:0] fast_clock_prescaler,
   output logic slow_clock,
   output logic [1:0] aux_clock,
   output logic [1:0] aux_tick,
   output logic irq
);

   // -------------------------------------------------------------------
   // Address map
   // -------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_CTRL =
      ADDR_W'(32'(`CLOCK_RESET_CONTROL_IDX) << 2);
   localparam logic [ADDR_W-1:0] ADDR_FAST =
      ADDR_W'(32'(`FAST_CLOCK_PRESCALER_IDX) << 2);
   localparam logic [ADDR_W-1:0] ADDR_SLOW =
      ADDR_W'(32'(`SLOW_CLOCK_PRESCALER_IDX) << 2);
   localparam logic [ADDR_W-1:0] ADDR_AUX =
      ADDR_W'(32'(`AUX_CLOCK_PRESCALER_IDX) << 2);
   localparam logic [ADDR_W-1:0] ADDR_STAT =
      ADDR_W'(32'(`EVENT_STATUS_IDX) << 2);
   localparam logic [ADDR_W-1:0] ADDR_MASK =
      ADDR_W'(32'(`EVENT_MASK_IDX) << 2);

   control_s control;
   logic [7:0] slow_clock_prescaler;
   logic [7:0] aux_clock_prescaler;
   event_s event_status;
   event_s event_mask;
   event_s event_set;
   logic [TIMER_W-1:0] startup_timer;
   logic pll_stable_q;
   logic main_good_q;

   // -------------------------------------------------------------------
   // AXI4-Lite write channel
   // -------------------------------------------------------------------
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic w_lane0_q;
   logic aw_take;
   logic w_take;
   logic do_write;
   logic [ADDR_W-1:0] wr_addr;
   logic [7:0] wr_byte;
   logic wr_lane0;
   logic wr_mapped;

   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   assign aw_take = awvalid && awready;
   assign w_take = wvalid && wready;
   assign do_write = (aw_held || aw_take) && (w_held || w_take);
   assign wr_addr = aw_held ? aw_addr_q : awaddr;
   assign wr_byte = w_held ? w_data_q[7:0] : wdata[7:0];
   assign wr_lane0 = w_held ? w_lane0_q : wstrb[0];
   assign wr_mapped = (wr_addr == ADDR_CTRL) || (wr_addr == ADDR_FAST) ||
      (wr_addr == ADDR_SLOW) || (wr_addr == ADDR_AUX) ||
      (wr_addr == ADDR_STAT) || (wr_addr == ADDR_MASK);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 32'h0;
         w_lane0_q <= 1'b0;
      end
      else if (do_write)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (w_take)
         begin
            w_held <= 1'b1;
            w_data_q <= wdata;
            w_lane0_q <= wstrb[0];
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= resp_okay;
      end
      else if (do_write)
      begin
         bvalid <= 1'b1;
         bresp <= wr_mapped ? resp_okay : resp_slverr;
      end
      else if (bready)
      begin
         bvalid <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite read channel
   // -------------------------------------------------------------------
   logic [7:0] rd_byte;
   logic rd_mapped;

   assign arready = !rvalid;

   always_comb
   begin
      rd_mapped = 1'b1;
      rd_byte = 8'h00;
      case (araddr)
         ADDR_CTRL: rd_byte = {2'b00, control[5:0]};
         ADDR_FAST: rd_byte = fast_clock_prescaler;
         ADDR_SLOW: rd_byte = slow_clock_prescaler;
         ADDR_AUX: rd_byte = aux_clock_prescaler;
         ADDR_STAT: rd_byte = {5'h00, event_status};
         ADDR_MASK: rd_byte = {5'h00, event_mask};
         default: rd_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= resp_okay;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rdata <= {24'h000000, rd_byte};
         rresp <= rd_mapped ? resp_okay : resp_slverr;
      end
      else if (rready)
      begin
         rvalid <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Control register with PLL interlocks
   // -------------------------------------------------------------------
   logic ctrl_wr;
   logic fast_clear_refused;
   logic pwd_set_refused;

   assign ctrl_wr = do_write && wr_lane0 && (wr_addr == ADDR_CTRL);
   // Clearing the fast select needs the PLL powered and stable.
   // A write that also asks for power-down is judged as power-down set.
   assign fast_clear_refused = ctrl_wr && !wr_byte[`FAST_SOURCE_BIT] &&
      (control.pll_power_down || wr_byte[`PLL_POWER_DOWN_BIT] ||
      !pll_stable); // see RULE7 RULE8
   // The PLL may not stop while it drives the system clock.
   assign pwd_set_refused = ctrl_wr && wr_byte[`PLL_POWER_DOWN_BIT] &&
      !control.fast_source_select; // see RULE10

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         control <= `CLOCK_RESET_CONTROL_RST; // see RULE6 RULE9 RULE13
      end
      else if (ctrl_wr)
      begin
         // Field placement follows the control register layout.
         control.slow_source_select <=
            wr_byte[`SLOW_SOURCE_BIT]; // see RULE5 RULE14
         control.fast_source_select <= wr_byte[`FAST_SOURCE_BIT] ||
            fast_clear_refused; // see RULE7 RULE8
         if (!pwd_set_refused)
         begin
            control.pll_power_down <=
               wr_byte[`PLL_POWER_DOWN_BIT]; // see RULE10
         end
         control.aux_one_enable <= wr_byte[`AUX_ONE_ENABLE_BIT];
         control.aux_two_enable <= wr_byte[`AUX_TWO_ENABLE_BIT];
         // Writing one keeps the flag; only a zero clears it.
         control.power_on_flag <= control.power_on_flag &&
            wr_byte[`POWER_ON_FLAG_BIT]; // see RULE13
      end
   end

   assign fast_source_select = control.fast_source_select; // see RULE6
   assign pll_stop = control.pll_power_down; // see RULE9

   // -------------------------------------------------------------------
   // Prescaler registers
   // -------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fast_clock_prescaler <= `FAST_CLOCK_PRESCALER_RST;
         slow_clock_prescaler <= `SLOW_CLOCK_PRESCALER_RST;
         aux_clock_prescaler <= `AUX_CLOCK_PRESCALER_RST;
      end
      else if (do_write && wr_lane0)
      begin
         if (wr_addr == ADDR_FAST)
         begin
            fast_clock_prescaler <= wr_byte;
         end
         if (wr_addr == ADDR_SLOW)
         begin
            slow_clock_prescaler <= wr_byte;
         end
         if (wr_addr == ADDR_AUX)
         begin
            aux_clock_prescaler <= wr_byte;
         end
      end
   end

   // -------------------------------------------------------------------
   // Start-up timer and internal reset
   // -------------------------------------------------------------------
   // The same timer serves power-up and every restart of the oscillator.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || stop_main_osc)
      begin
         startup_timer <= TIMER_PRESET; // see RULE2 RULE15
      end
      else if (main_osc_running && (startup_timer != '0))
      begin
         startup_timer <= startup_timer - 1'b1; // see RULE2 RULE15
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         main_good_q <= 1'b0;
         internal_reset_n <= 1'b0;
      end
      else
      begin
         main_good_q <= (startup_timer == '0); // see RULE15
         // The pin is trusted to stay low until the clock dies.
         internal_reset_n <= (startup_timer == '0) &&
            reset_pin_n; // see RULE3 RULE4
      end
   end

   assign main_clock_good = main_good_q;

   // -------------------------------------------------------------------
   // Slow clock prescaler and glitch-free source mux
   // -------------------------------------------------------------------
   logic [7:0] slow_cnt;
   logic presc_clk;
   logic slow_active_sel;

   // The prescaler stops once the oscillator has taken over.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || slow_active_sel)
      begin
         slow_cnt <= 8'h00;
         presc_clk <= 1'b0;
      end
      else if (slow_cnt == slow_clock_prescaler)
      begin
         slow_cnt <= 8'h00;
         presc_clk <= !presc_clk;
      end
      else
      begin
         slow_cnt <= slow_cnt + 8'h01;
      end
   end

   // Sources change over only while both are low, so no runt appears.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         slow_active_sel <= 1'b0;
         slow_clock <= 1'b0;
      end
      else
      begin
         if ((slow_active_sel != control.slow_source_select) &&
            !presc_clk && !slow_osc_in)
         begin
            slow_active_sel <= control.slow_source_select; // see RULE17
         end
         slow_clock <= slow_active_sel ? slow_osc_in :
            presc_clk; // see RULE5
      end
   end

   // -------------------------------------------------------------------
   // Auxiliary clocks
   // -------------------------------------------------------------------
   logic [3:0] aux_div [2];
   logic [3:0] aux_cnt [2];
   logic [1:0] aux_gate;
   logic [1:0] aux_run;

   assign aux_div[0] = aux_clock_prescaler[`AUX_ONE_DIV_LSB +: 4];
   assign aux_div[1] = aux_clock_prescaler[`AUX_TWO_DIV_LSB +: 4];
   assign aux_gate[0] = control.aux_one_enable && main_good_q; // see RULE11
   assign aux_gate[1] = control.aux_two_enable && main_good_q; // see RULE12

   // A period always runs to its end, so gating never cuts a pulse short.
   // A divisor of zero leaves the clock low; the tick then fires each cycle.
   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_aux
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               aux_cnt[i] <= 4'h0;
               aux_run[i] <= 1'b0;
               aux_clock[i] <= 1'b0;
               aux_tick[i] <= 1'b0;
            end
            else if (aux_cnt[i] == 4'h0)
            begin
               aux_run[i] <= aux_gate[i]; // see RULE1 RULE17
               aux_tick[i] <= aux_gate[i];
               aux_cnt[i] <= aux_gate[i] ? aux_div[i] : 4'h0; // see RULE16
               aux_clock[i] <= aux_gate[i] && (aux_div[i] != 4'h0);
            end
            else
            begin
               aux_tick[i] <= 1'b0;
               aux_cnt[i] <= aux_cnt[i] - 4'h1;
               aux_clock[i] <= (aux_cnt[i] - 4'h1) > (aux_div[i] >> 1);
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // Event status, mask and interrupt
   // -------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pll_stable_q <= 1'b0;
      end
      else
      begin
         pll_stable_q <= pll_stable;
      end
   end

   assign event_set.main_clock_became_good =
      (startup_timer == '0) && !main_good_q;
   assign event_set.pll_became_stable = pll_stable && !pll_stable_q;
   assign event_set.write_refused = fast_clear_refused || pwd_set_refused;

   // A new event outranks a clear in the same cycle.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         event_status <= '0;
         event_mask <= `EVENT_MASK_RST;
      end
      else
      begin
         if (do_write && wr_lane0 && (wr_addr == ADDR_STAT))
         begin
            event_status <= (event_status & ~wr_byte[2:0]) | event_set;
         end
         else
         begin
            event_status <= event_status | event_set;
         end
         if (do_write && wr_lane0 && (wr_addr == ADDR_MASK))
         begin
            event_mask <= wr_byte[2:0];
         end
      end
   end

   assign irq = |(event_status & event_mask);

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_aux_one_idle;
      (aux_cnt[0] == 4'h0) && !aux_gate[0];
   endsequence

   sequence s_aux_two_idle;
      (aux_cnt[1] == 4'h0) && !aux_gate[1];
   endsequence

   pll_lock_pair_a: assert property (
      !(!control.fast_source_select && control.pll_power_down)) // see RULE7
      else $error("PLL powered down while it drives the system clock.");

   fast_clear_stable_a: assert property (
      $fell(control.fast_source_select) |-> $past(pll_stable)) // see RULE8
      else $error("Fast select cleared before the PLL was stable.");

   pwd_refused_a: assert property (
      pwd_set_refused |=> !control.pll_power_down) // see RULE10
      else $error("Power-down accepted while PLL drives the clock.");

   timer_preset_a: assert property (
      stop_main_osc |=> (startup_timer == TIMER_PRESET)) // see RULE15
      else $error("Start-up timer not preset during oscillator stop.");

   timer_count_a: assert property (
      aresetn && !stop_main_osc && main_osc_running &&
      (startup_timer != '0) |=>
      (startup_timer == $past(startup_timer) - 1'b1)) // see RULE2
      else $error("Start-up timer did not count down.");

   reset_release_a: assert property (
      $rose(internal_reset_n) |->
      $past(reset_pin_n) && ($past(startup_timer) == '0)) // see RULE3
      else $error("Internal reset released too early.");

   por_never_set_a: assert property (
      !$rose(control.power_on_flag)) // see RULE13
      else $error("Power-on flag set after reset.");

   aux_one_stop_a: assert property (
      s_aux_one_idle |=> !aux_clock[0] && !aux_tick[0]) // see RULE11
      else $error("Auxiliary clock one ran while gated off.");

   aux_two_stop_a: assert property (
      s_aux_two_idle |=> !aux_clock[1] && !aux_tick[1]) // see RULE12
      else $error("Auxiliary clock two ran while gated off.");

   slow_mux_a: assert property (
      slow_active_sel && (control.slow_source_select) |=>
      (slow_clock == $past(slow_osc_in))) // see RULE5
      else $error("Slow clock does not follow the oscillator.");

endmodule : clock_select_reset_control

// File: clock_reset_cfg.svh
// Register indices, field positions, reset values and timer constants.
`ifndef CLOCK_RESET_CFG_SVH
`define CLOCK_RESET_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CLOCK_RESET_CONTROL_IDX 24'hfffc40
`define FAST_CLOCK_PRESCALER_IDX 24'hfffc42
`define SLOW_CLOCK_PRESCALER_IDX 24'hfffc44
`define AUX_CLOCK_PRESCALER_IDX 24'hfffc46
`define EVENT_STATUS_IDX 24'hfffc48
`define EVENT_MASK_IDX 24'hfffc4a

// ----------------------------------------------------------------------
// Control and auxiliary prescaler register fields
// ----------------------------------------------------------------------
`define SLOW_SOURCE_BIT 0
`define FAST_SOURCE_BIT 1
`define PLL_POWER_DOWN_BIT 2
`define AUX_ONE_ENABLE_BIT 3
`define AUX_TWO_ENABLE_BIT 4
`define POWER_ON_FLAG_BIT 5
`define AUX_ONE_DIV_LSB 0
`define AUX_TWO_DIV_LSB 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CLOCK_RESET_CONTROL_RST 8'h26
`define FAST_CLOCK_PRESCALER_RST 8'h4f
`define SLOW_CLOCK_PRESCALER_RST 8'hb6
`define AUX_CLOCK_PRESCALER_RST 8'hff
`define EVENT_MASK_RST 3'h0

// ----------------------------------------------------------------------
// Timers
// ----------------------------------------------------------------------
`define STARTUP_TIMER_WIDTH 14
`define STARTUP_TIMER_PRESET 14'h3fff

`endif

// File: clock_reset_pkg.sv
// Types shared by the clock-select and reset-control block.
package clock_reset_pkg;

   // -------------------------------------------------------------------
   // Register layouts
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] reserved;
      logic power_on_flag;
      logic aux_two_enable;
      logic aux_one_enable;
      logic pll_power_down;
      logic fast_source_select;
      logic slow_source_select;
   } control_s;

   typedef struct packed {
      logic write_refused;
      logic pll_became_stable;
      logic main_clock_became_good;
   } event_s;

   typedef enum logic [1:0] {
      resp_okay = 2'h0,
      resp_slverr = 2'h2
   } axi_resp_e;

endpackage : clock_reset_pkg

// File: tb_top.sv
// Self-checking testbench for the clock-select and reset-control block.
`timescale 1ns/10ps
`include "clock_reset_cfg.svh"

module tb_top
   import clock_reset_pkg::*;
   ;
   // ------------------------------------------------------------------
   // Signals and stimulus table
   // ------------------------------------------------------------------
   localparam logic [13:0] PRESET = 14'h0010;
   localparam logic [31:0] CTRL = 32'(`CLOCK_RESET_CONTROL_IDX) << 2;
   localparam logic [31:0] FAST = 32'(`FAST_CLOCK_PRESCALER_IDX) << 2;
   localparam logic [31:0] SLOW = 32'(`SLOW_CLOCK_PRESCALER_IDX) << 2;
   localparam logic [31:0] AUX = 32'(`AUX_CLOCK_PRESCALER_IDX) << 2;
   localparam logic [31:0] STAT = 32'(`EVENT_STATUS_IDX) << 2;
   localparam logic [31:0] MASK = 32'(`EVENT_MASK_IDX) << 2;
   localparam logic [1:0] OK = resp_okay;
   localparam logic [1:0] ERR = resp_slverr;
   typedef struct {
      logic [31:0] a;
      logic [7:0] d;
      logic pll;
      logic [7:0] e;
      logic [1:0] r;
   } row_s;
   row_s rows [10];
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = '0;
   logic awvalid = 1'b0;
   logic [31:0] wdata = '0;
   logic wvalid = 1'b0;
   logic [31:0] araddr = '0;
   logic arvalid = 1'b0;
   logic bready = 1'b1;
   logic rready = 1'b1;
   logic stop_main_osc = 1'b0;
   logic main_osc_running = 1'b0;
   logic reset_pin_n = 1'b1;
   logic pll_stable = 1'b0;
   logic slow_osc_in = 1'b0;
   logic [1:0] osc_div = 2'h0;
   logic awready, wready, bvalid, arready, rvalid, internal_reset_n;
   logic main_clock_good, pll_stop, fast_source_select, slow_clock, irq;
   logic [1:0] bresp, rresp, aux_clock, aux_tick;
   logic [31:0] rdata;
   logic [7:0] fast_clock_prescaler;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;

   clock_select_reset_control #(.TIMER_PRESET(PRESET)) DUT (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .stop_main_osc(stop_main_osc), .main_osc_running(main_osc_running),
      .reset_pin_n(reset_pin_n), .pll_stable(pll_stable),
      .slow_osc_in(slow_osc_in), .internal_reset_n(internal_reset_n),
      .main_clock_good(main_clock_good), .pll_stop(pll_stop),
      .fast_source_select(fast_source_select),
      .fast_clock_prescaler(fast_clock_prescaler),
      .slow_clock(slow_clock), .aux_clock(aux_clock), .aux_tick(aux_tick),
      .irq(irq));

   initial
   begin
      forever #4 aclk = ~aclk;
   end

   // The slow oscillator model has a period of eight main clock cycles.
   always @(posedge aclk)
   begin
      osc_div <= osc_div + 2'h1;
      if (&osc_div)
         slow_osc_in <= !slow_osc_in;
   end

   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         errors++;
         test_done();
      end
   end

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] exp,
                        input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         errors++;
      end
   endtask : check

   // Bready and rready stay high throughout, so only valids are dropped.
   task automatic axi_write(input logic [31:0] a, input logic [7:0] d,
                            output logic [1:0] r);
      r = 2'h3;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            r = bresp;
            break;
         end
      end
   endtask : axi_write

   task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      r = 2'h3;
      d = 'x;
      araddr <= a;
      arvalid <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            d = rdata;
            r = rresp;
            break;
         end
      end
   endtask : axi_read

   task automatic wr_rd(input logic [31:0] a, input logic [7:0] d,
                        input logic [7:0] e, input logic [1:0] rs);
      logic [1:0] r;
      logic [31:0] q;
      axi_write(a, d, r);
      check("bresp", 32'(rs), 32'(r));
      axi_read(a, q, r);
      check("rresp", 32'(rs), 32'(r));
      check("rdata", 32'(e), q);
   endtask : wr_rd

   task automatic rises(input int n, output int c0, output int c1,
                        output int cs);
      logic [2:0] p;
      c0 = 0;
      c1 = 0;
      cs = 0;
      p = {slow_clock, aux_clock};
      repeat (n)
      begin
         @(negedge aclk);
         c0 += int'(aux_clock[0] && !p[0]);
         c1 += int'(aux_clock[1] && !p[1]);
         cs += int'(slow_clock && !p[2]);
         p = {slow_clock, aux_clock};
      end
      @(posedge aclk);
   endtask : rises

   task automatic test_done();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      logic [31:0] q;
      logic [1:0] r;
      int c0, c1, cs, i;
      rows = '{
         '{CTRL, 8'h24, 1'b0, 8'h26, OK}, '{CTRL, 8'h22, 1'b0, 8'h22, OK},
         '{CTRL, 8'h20, 1'b0, 8'h22, OK}, '{CTRL, 8'h20, 1'b1, 8'h20, OK},
         '{CTRL, 8'h26, 1'b1, 8'h22, OK}, '{CTRL, 8'h1b, 1'b1, 8'h1b, OK},
         '{CTRL, 8'h3b, 1'b1, 8'h1b, OK}, '{AUX, 8'h11, 1'b1, 8'h11, OK},
         '{FAST, 8'h5a, 1'b1, 8'h5a, OK}, '{32'h10, 8'h5a, 1'b1, 8'h0, ERR}};
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (30) @(posedge aclk);
      check("held reset", 32'h0, 32'(internal_reset_n));
      main_osc_running <= 1'b1;
      repeat (int'(PRESET)) @(posedge aclk);
      @(negedge aclk);
      check("early reset", 32'h0, 32'(internal_reset_n));
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      check("reset out", 32'h1, 32'(internal_reset_n));
      @(posedge aclk);
      check("fast out", 32'h1, 32'(fast_source_select));
      check("pll stop", 32'h1, 32'(pll_stop));
      axi_read(CTRL, q, r);
      check("control", 32'h26, q);
      axi_read(SLOW, q, r);
      check("slow presc", 32'hb6, q);
      axi_read(AUX, q, r);
      check("aux presc", 32'hff, q);
      axi_read(MASK, q, r);
      check("mask", 32'h0, q);
      foreach (rows[k])
      begin
         pll_stable <= rows[k].pll;
         wr_rd(rows[k].a, rows[k].d, rows[k].e, rows[k].r);
         if (rows[k].a == CTRL)
         begin
            check("fast sel", 32'(rows[k].e[1]), 32'(fast_source_select));
            check("pll_stop", 32'(rows[k].e[2]), 32'(pll_stop));
         end
      end
      check("fast presc", 32'h5a, 32'(fast_clock_prescaler));
      rises(40, c0, c1, cs);
      check("aux one", 32'h1, 32'(c0 >= 19 && c0 <= 21));
      check("aux two", 32'h1, 32'(c1 >= 19 && c1 <= 21));
      check("slow osc", 32'h1, 32'(cs >= 4 && cs <= 6));
      stop_main_osc <= 1'b1;
      rises(4, c0, c1, cs);
      check("good off", 32'h0, 32'(main_clock_good));
      rises(20, c0, c1, cs);
      check("aux gated", 32'h0, 32'(c0 + c1));
      check("tick off", 32'h0, 32'(aux_tick));
      stop_main_osc <= 1'b0;
      repeat (14) @(posedge aclk);
      check("good early", 32'h0, 32'(main_clock_good));
      for (i = 0; i < 10 && main_clock_good !== 1'b1; i++)
         @(posedge aclk);
      check("good back", 32'h1, 32'(main_clock_good));
      reset_pin_n <= 1'b0;
      repeat (3) @(posedge aclk);
      check("pin reset", 32'h0, 32'(internal_reset_n));
      reset_pin_n <= 1'b1;
      repeat (3) @(posedge aclk);
      check("pin free", 32'h1, 32'(internal_reset_n));
      check("irq masked", 32'h0, 32'(irq));
      wr_rd(MASK, 8'h04, 8'h04, OK);
      check("irq on", 32'h1, 32'(irq));
      wr_rd(STAT, 8'h04, 8'h03, OK);
      check("irq cleared", 32'h0, 32'(irq));
      wr_rd(CTRL, 8'h03, 8'h03, OK);
      rises(20, c0, c1, cs);
      check("aux off", 32'h0, 32'(c0 + c1));
      wr_rd(CTRL, 8'h04, 8'h06, OK);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      axi_read(CTRL, q, r);
      check("ctrl again", 32'h26, q);
      test_done();
   end
endmodule : tb_top
